// ---- src/timer_pwm_single_pulse.sv ----
// 10-bit compare timer output stage: edge-aligned PWM and single pulse
// assumes APB3 software access, TICK_I as the selected timer clock strobe
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/10ps

module timer_pwm_single_pulse #(
    parameter int CNT_W = timer_pwm_pkg::CNT_W
) (
    // clock, reset, enable
    input  wire logic                              CLK_SYS_I,
    input  wire logic                              RSTN_I,
    input  wire logic                              CE_I,
    // timer clock strobe and trigger pin
    input  wire logic                              TICK_I,
    input  wire logic                              EXT_TRIG_I,
    // apb slave
    input  wire logic                              PSEL_I,
    input  wire logic                              PENABLE_I,
    input  wire logic                              PWRITE_I,
    input  wire logic [timer_pwm_pkg::ADDR_W-1:0]  PADDR_I,
    input  wire logic [timer_pwm_pkg::DATA_W-1:0]  PWDATA_I,
    output logic      [timer_pwm_pkg::DATA_W-1:0]  PRDATA_O,
    output logic                                   PREADY_O,
    output logic                                   PSLVERR_O,
    // output pin and status
    output logic                                   TMR_OUT_O,
    output logic                                   TMR_OE_O,
    output logic      [CNT_W-1:0]                  COUNT_O,
    output logic                                   MATCH_A_FLAG_O,
    output logic                                   MATCH_P_FLAG_O
);
    import timer_pwm_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [CNT_W-1:0]  cnt;
        logic              run;
        logic [CNT_W-1:0]  cmpa;
        logic [P_W-1:0]    cmpp;
        logic [1:0]        mode;
        logic [1:0]        io;
        logic              oc;
        logic              pol;
        logic              dpx;
        logic              cclr;
        logic              flag_a;
        logic              flag_p;
        logic              trig_d;
        logic              out;
        logic              rdy;
        logic              err;
        logic [DATA_W-1:0] rdata;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    // zero in a compare register stands for the full 1024 count
    function automatic logic [CNT_W:0] zero_full(input logic [CNT_W-1:0] v);
        return (v == '0) ? FULL_COUNT : {1'b0, v};
    endfunction

    // ----------------------------------------------------------------
    // decode and comparators
    // ----------------------------------------------------------------
    logic             pwm_mode;
    logic             pulse_mode;
    logic [CNT_W:0]   a_val;
    logic [CNT_W:0]   p_val;
    logic [CNT_W:0]   duty_val;
    logic [CNT_W:0]   nxt_p_val;
    logic [CNT_W:0]   per_val;
    logic             duty_full;
    logic             hit_a;
    logic             hit_p;
    logic             duty_below;
    logic             tick;
    logic             ev_a;
    logic             ev_p;
    logic             trig_rise;
    logic             run_rise;
    logic             do_clear;
    logic             wr_done;
    logic             rd_cap;
    logic             level;
    logic [CNT_W-1:0] cnt_inc;

    assign pwm_mode   = (st_r.mode == MODE_PWM) && (st_r.io != IO_PULSE);
    assign pulse_mode = (st_r.mode == MODE_PWM) && (st_r.io == IO_PULSE);
    assign a_val      = zero_full(st_r.cmpa);
    // code 0 of compare P stands for 1024, others step by 128
    assign p_val      = zero_full({st_r.cmpp, {P_SHIFT{1'b0}}});
    // duty and period are taken from the values the flip-flops take next
    assign nxt_p_val  = zero_full({st_nxt.cmpp, {P_SHIFT{1'b0}}});
    assign duty_val   = st_nxt.dpx ? nxt_p_val : {1'b0, st_nxt.cmpa};
    assign per_val    = st_nxt.dpx ? zero_full(st_nxt.cmpa) : nxt_p_val;
    assign duty_full  = (duty_val >= per_val);
    assign tick       = CE_I && TICK_I && st_r.run;
    assign ev_a       = tick && hit_a;
    assign ev_p       = tick && hit_p;
    assign trig_rise  = EXT_TRIG_I && !st_r.trig_d;
    assign cnt_inc    = st_r.cnt + CNT_W'(1);
    assign wr_done    = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O;
    assign rd_cap     = PSEL_I && CE_I && !st_r.rdy;

    pwm_compare #(
        .W       (CNT_W)
    ) u_cmp_a (
        .count_i (st_r.cnt),
        .value_i (a_val),
        .hit_o   (hit_a),
        .below_o ()
    );

    pwm_compare #(
        .W       (CNT_W)
    ) u_cmp_p (
        .count_i (st_r.cnt),
        .value_i (p_val),
        .hit_o   (hit_p),
        .below_o ()
    );

    // duty is judged on the count the flip-flops take next, so the pin
    // moves in the same cycle as the counter
    pwm_compare #(
        .W       (CNT_W)
    ) u_cmp_duty (
        .count_i (st_nxt.cnt),
        .value_i (duty_val),
        .hit_o   (),
        .below_o (duty_below)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt        = st_r;
        st_nxt.trig_d = EXT_TRIG_I;
        // counter clear select per mode
        if (pwm_mode) begin
            do_clear = st_r.dpx ? ev_a : ev_p;
        end else if (pulse_mode) begin
            do_clear = 1'b0;
        end else begin
            do_clear = st_r.cclr ? ev_a : ev_p;
        end

        // software writes
        if (wr_done) begin
            unique case (PADDR_I)
                OFS_CTRL: begin
                    st_nxt.run  = PWDATA_I[CTRL_RUN_BIT];
                    st_nxt.dpx  = PWDATA_I[CTRL_DPX_BIT];
                    st_nxt.cclr = PWDATA_I[CTRL_CCLR_BIT];
                    st_nxt.pol  = PWDATA_I[CTRL_POL_BIT];
                    st_nxt.oc   = PWDATA_I[CTRL_OC_BIT];
                    st_nxt.io   = PWDATA_I[CTRL_IO_LSB +: 2];
                    st_nxt.mode = PWDATA_I[CTRL_MODE_LSB +: 2];
                end
                OFS_CMPA: st_nxt.cmpa = PWDATA_I[CNT_W-1:0];
                OFS_CMPP: st_nxt.cmpp = PWDATA_I[P_W-1:0];
                OFS_FLAGS: begin
                    st_nxt.flag_a = st_r.flag_a && !PWDATA_I[FLAG_A_BIT];
                    st_nxt.flag_p = st_r.flag_p && !PWDATA_I[FLAG_P_BIT];
                end
                default: ;
            endcase
        end

        // a match ends the pulse unless software sets run in the same cycle
        if (pulse_mode && ev_a && !(wr_done && PADDR_I == OFS_CTRL)) begin
            st_nxt.run = 1'b0;
        end
        if (pulse_mode && trig_rise) begin
            st_nxt.run = 1'b1;
        end

        // hardware set wins over a write-one clear
        if (ev_a) begin
            st_nxt.flag_a = 1'b1;
        end
        if (ev_p && !pulse_mode && (pwm_mode || !st_r.cclr)) begin
            st_nxt.flag_p = 1'b1;
        end

        // counter
        run_rise = st_nxt.run && !st_r.run;
        if (run_rise) begin
            st_nxt.cnt = CNT_RST;
        end else if (tick) begin
            if (do_clear) begin
                st_nxt.cnt = CNT_RST;
            end else if (pulse_mode && ev_a) begin
                st_nxt.cnt = st_r.cnt;
            end else begin
                st_nxt.cnt = cnt_inc;
            end
        end

        // output pin: active level is the initial level, then inverted
        if (st_nxt.mode == MODE_PWM && st_nxt.io == IO_PULSE) begin
            level = st_nxt.run ? st_nxt.oc : !st_nxt.oc;
        end else if (st_nxt.mode == MODE_PWM) begin
            unique case (st_nxt.io)
                IO_FORCE_LO: level = !st_nxt.oc;
                IO_FORCE_HI: level = st_nxt.oc;
                // duty at or above period keeps the count below duty
                default: level = (st_nxt.run && (duty_below || duty_full)) ? st_nxt.oc
                                                                           : !st_nxt.oc;
            endcase
        end else begin
            level = !st_nxt.oc;
        end
        st_nxt.out = level ^ st_nxt.pol;

        // apb read data and error caught before the access completes
        if (rd_cap) begin
            st_nxt.rdy   = 1'b1;
            st_nxt.err   = 1'b0;
            st_nxt.rdata = '0;
            unique case (PADDR_I)
                OFS_CTRL: begin
                    st_nxt.rdata[CTRL_RUN_BIT]      = st_r.run;
                    st_nxt.rdata[CTRL_DPX_BIT]      = st_r.dpx;
                    st_nxt.rdata[CTRL_CCLR_BIT]     = st_r.cclr;
                    st_nxt.rdata[CTRL_POL_BIT]      = st_r.pol;
                    st_nxt.rdata[CTRL_OC_BIT]       = st_r.oc;
                    st_nxt.rdata[CTRL_IO_LSB +: 2]  = st_r.io;
                    st_nxt.rdata[CTRL_MODE_LSB +: 2] = st_r.mode;
                end
                OFS_CMPA:  st_nxt.rdata[CNT_W-1:0] = st_r.cmpa;
                OFS_CMPP:  st_nxt.rdata[P_W-1:0] = st_r.cmpp;
                OFS_COUNT: st_nxt.rdata[CNT_W-1:0] = st_r.cnt;
                OFS_FLAGS: begin
                    st_nxt.rdata[FLAG_A_BIT] = st_r.flag_a;
                    st_nxt.rdata[FLAG_P_BIT] = st_r.flag_p;
                end
                default: st_nxt.err = 1'b1;
            endcase
        end else if (PSEL_I && PENABLE_I && PREADY_O) begin
            st_nxt.rdy = 1'b0;
        end

        // a low clock enable freezes every flip-flop
        if (!CE_I) begin
            st_nxt = st_r;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            st_r      <= '0;
            st_r.cnt  <= CNT_RST;
            st_r.cmpa <= CMPA_RST;
            st_r.cmpp <= CMPP_RST;
            st_r.mode <= MODE_RST;
            st_r.io   <= IO_RST;
            st_r.out  <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign PRDATA_O       = st_r.rdata;
    assign PREADY_O       = CE_I && PSEL_I && PENABLE_I && st_r.rdy;
    assign PSLVERR_O      = PREADY_O && st_r.err;
    assign TMR_OUT_O      = st_r.out;
    assign TMR_OE_O       = (st_r.mode != MODE_TIMER);
    assign COUNT_O        = st_r.cnt;
    assign MATCH_A_FLAG_O = st_r.flag_a;
    assign MATCH_P_FLAG_O = st_r.flag_p;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RSTN_I);

    a_swap_clear:
    assert property (CE_I && pwm_mode && st_r.dpx && ev_a && !run_rise
                     |=> st_r.cnt == CNT_RST)
        else $error("swap select 1: match A did not clear counter");

    a_noswap_clear:
    assert property (CE_I && pwm_mode && !st_r.dpx && ev_p && !run_rise
                     |=> st_r.cnt == CNT_RST)
        else $error("swap select 0: match P did not clear counter");

    a_pulse_lead:
    assert property (CE_I && pulse_mode && run_rise && !wr_done
                     |=> st_r.cnt == CNT_RST && st_r.out == (st_r.oc ^ st_r.pol))
        else $error("pulse leading edge or counter restart missing");

    a_trig_run:
    assert property (CE_I && pulse_mode && EXT_TRIG_I && !st_r.trig_d
                     |=> st_r.run)
        else $error("trigger edge did not set run bit");

    a_pulse_stop:
    assert property (CE_I && pulse_mode && ev_a && !trig_rise && !wr_done
                     |=> !st_r.run && st_r.flag_a && $stable(st_r.cnt))
        else $error("match A did not end pulse and stop counter");

    a_pulse_trail:
    assert property (pulse_mode && !st_r.run
                     |-> TMR_OUT_O == !(st_r.oc ^ st_r.pol))
        else $error("pulse level wrong while run bit clear");

    a_full_duty:
    assert property (pwm_mode && st_r.io != IO_FORCE_LO && st_r.io != IO_FORCE_HI
                     && st_r.run
                     && (st_r.dpx ? p_val : {1'b0, st_r.cmpa}) >= (st_r.dpx ? a_val : p_val)
                     |-> TMR_OUT_O == (st_r.oc ^ st_r.pol))
        else $error("duty at or above period not held active");

    a_count_step:
    assert property (CE_I && tick && !do_clear && !(pulse_mode && ev_a)
                     && !run_rise |=> st_r.cnt == $past(cnt_inc))
        else $error("counter did not advance on tick");

    a_count_hold:
    assert property (CE_I && !tick && !run_rise |=> $stable(st_r.cnt))
        else $error("counter moved without a tick");

    a_flag_p_set:
    assert property (CE_I && pwm_mode && ev_p |=> st_r.flag_p)
        else $error("match P flag not set in PWM");

endmodule

// ---- pkg/timer_pwm_pkg.sv ----
// constants of the 10-bit compare timer: register map, fields, resets
// assumes an APB3 master and a one-cycle timer tick strobe
//
// Notes on behaviour
// - swap select 1 in PWM: period from compare A, duty from compare P
// - swap select 1: P codes 1..7 give duty 128..896 clocks, code 0 gives 1024
// - PWM with swap select 0: compare P match clears the counter
// - PWM with swap select 1: compare A match clears the counter
// - each counter clear in PWM ends one period and starts the next
// - counting and comparing continue while the pin is forced by action 00/01
// - clear source select has no effect in PWM mode
// - run bit rising edge in single pulse starts counter and pulse leading edge
// - trigger pin active edge sets run bit in single pulse mode
// - pulse trailing edge when run bit clears, by software or match A
// - compare A match clears run bit in single pulse, setting width
// - counter stops on compare A match in single pulse mode
// - compare A match sets match A flag in single pulse mode
// - in single pulse the counter returns to zero only on run rising edge
// - single pulse ignores compare P, clear source and swap select
// - duty equal to or above period gives 100% duty
// - PWM sets separate flags on each compare A and compare P match
// - initial level picks PWM polarity, invert bit reverses the output

package timer_pwm_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int CNT_W  = 10;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int P_W    = 3;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CTRL  = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CMPA  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CMPP  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h10;

    // ----------------------------------------------------------------
    // control fields and flag bits
    // ----------------------------------------------------------------
    localparam int CTRL_RUN_BIT  = 0;
    localparam int CTRL_DPX_BIT  = 1;
    localparam int CTRL_CCLR_BIT = 2;
    localparam int CTRL_POL_BIT  = 3;
    localparam int CTRL_OC_BIT   = 4;
    localparam int CTRL_IO_LSB   = 5;
    localparam int CTRL_MODE_LSB = 8;
    localparam int FLAG_A_BIT    = 0;
    localparam int FLAG_P_BIT    = 1;

    // ----------------------------------------------------------------
    // mode and output action codes
    // ----------------------------------------------------------------
    localparam logic [1:0] MODE_PWM    = 2'h2;
    localparam logic [1:0] MODE_TIMER  = 2'h3;
    localparam logic [1:0] IO_FORCE_LO = 2'h0;
    localparam logic [1:0] IO_FORCE_HI = 2'h1;
    localparam logic [1:0] IO_PULSE    = 2'h3;

    // ----------------------------------------------------------------
    // counts and reset values
    // ----------------------------------------------------------------
    localparam logic [CNT_W:0]   FULL_COUNT = 11'h400;
    localparam int               P_SHIFT    = 7;
    localparam logic [CNT_W-1:0] CNT_RST    = 10'h000;
    localparam logic [CNT_W-1:0] CMPA_RST   = 10'h000;
    localparam logic [P_W-1:0]   CMPP_RST   = 3'h0;
    localparam logic [1:0]       MODE_RST   = 2'h0;
    localparam logic [1:0]       IO_RST     = 2'h0;

endpackage

// ---- src/pwm_compare.sv ----
// one comparator of the timer: match on the last count and below test
// assumes the value is the decoded compare value, 0 coded as full count
`timescale 1ns/10ps

module pwm_compare #(
    parameter int W = 10
) (
    // count and compare value
    input  wire logic [W-1:0] count_i,
    input  wire logic [W:0]   value_i,
    // results
    output logic              hit_o,
    output logic              below_o
);

    logic [W:0] count_plus;

    // the match fires on the count that the next tick would carry to value
    assign count_plus = {1'b0, count_i} + (W+1)'(1);
    assign hit_o      = (count_plus == value_i);
    assign below_o    = ({1'b0, count_i} < value_i);

endmodule

// ---- verification/tb_top.sv ----
// self-checking bench of the 10-bit timer output stage: pwm and single pulse
// assumes the timer design with its apb slave; the tick strobe runs every clock here except in the short count hold test
`timescale 1ns/10ps

`define CHK(got, exp, msg) begin \
    compares++; \
    if ((got) !== (exp)) begin \
        num_errors++; \
        $display("wrong value at %0t: %s", $time, msg); \
    end \
end

module tb_top;
    import timer_pwm_pkg::*;

    localparam logic [1:0] IO_WAVE = 2'h2;

    logic              clk_sys = 1'b0;
    logic              rstn;
    logic              ce;
    logic              tick;
    logic              ext_trig;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic              tmr_out;
    logic              tmr_oe;
    logic [CNT_W-1:0]  count;
    logic              flag_a;
    logic              flag_p;
    int                num_errors = 0;
    int                compares = 0;

    always #2.5 clk_sys = ~clk_sys;

    timer_pwm_single_pulse #(.CNT_W(CNT_W)) u_dut (
        .CLK_SYS_I     (clk_sys),
        .RSTN_I        (rstn),
        .CE_I          (ce),
        .TICK_I        (tick),
        .EXT_TRIG_I    (ext_trig),
        .PSEL_I        (psel),
        .PENABLE_I     (penable),
        .PWRITE_I      (pwrite),
        .PADDR_I       (paddr),
        .PWDATA_I      (pwdata),
        .PRDATA_O      (prdata),
        .PREADY_O      (pready),
        .PSLVERR_O     (pslverr),
        .TMR_OUT_O     (tmr_out),
        .TMR_OE_O      (tmr_oe),
        .COUNT_O       (count),
        .MATCH_A_FLAG_O(flag_a),
        .MATCH_P_FLAG_O(flag_p)
    );

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic conclude();
        if (num_errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic apb(input logic wr_en, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] rd,
                       output logic err);
        int   n;
        logic ok;
        n = 0;
        ok = 1'b0;
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr_en;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // the answer is looked at mid-cycle; it stands until the edge that samples it
        do begin
            @(negedge clk_sys);
            ok  = (pready === 1'b1);
            rd  = prdata;
            err = pslverr;
            @(posedge clk_sys);
            n++;
        end while (!ok && n < 50);
        if (!ok) begin
            num_errors++;
            $display("wrong value at %0t: apb answer timed out", $time);
            conclude();
        end else begin
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] r;
        logic              e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
        logic e;
        apb(1'b0, a, 32'h0000_0000, v, e);
    endtask

    function automatic logic [DATA_W-1:0] ctl(input logic run, dpx, cclr, pol, oc,
                                              input logic [1:0] io, mode);
        ctl = (DATA_W'(mode) << CTRL_MODE_LSB) | (DATA_W'(io) << CTRL_IO_LSB)
            | (DATA_W'(oc) << CTRL_OC_BIT) | (DATA_W'(pol) << CTRL_POL_BIT)
            | (DATA_W'(cclr) << CTRL_CCLR_BIT) | (DATA_W'(dpx) << CTRL_DPX_BIT)
            | DATA_W'(run);
    endfunction

    // settle one longest period, then count high samples and the top count
    task automatic pwm_win(input int n, output int h, output logic [CNT_W-1:0] mx);
        h = 0;
        mx = '0;
        repeat (1024) @(posedge clk_sys);
        repeat (n) begin
            @(negedge clk_sys);
            if (tmr_out === 1'b1) h++;
            if (count > mx) mx = count;
        end
    endtask

    task automatic pulse_len(output int h);
        int n;
        h = 0;
        n = 0;
        @(negedge clk_sys);
        while (tmr_out !== 1'b1 && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        while (tmr_out === 1'b1 && h < 2000) begin
            @(negedge clk_sys);
            h++;
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic reset_values();
        logic [DATA_W-1:0] v;
        logic              e;
        `CHK(tmr_out, 1'b1, "pin reset level")
        `CHK(tmr_oe, 1'b1, "pin enable at reset")
        rd(OFS_CTRL, v);
        `CHK(v, 32'h0000_0000, "control reset")
        rd(OFS_CMPA, v);
        `CHK(v, 32'h0000_0000, "compare a reset")
        wr(OFS_COUNT, 32'h0000_0005);
        rd(OFS_COUNT, v);
        `CHK(v, 32'h0000_0000, "count write ignored")
        apb(1'b0, 8'h14, 32'h0000_0000, v, e);
        `CHK(e, 1'b1, "unmapped error")
        `CHK(v, 32'h0000_0000, "unmapped read data")
    endtask

    task automatic pwm_swap_one();
        int                h;
        logic [CNT_W-1:0]  mx;
        logic [DATA_W-1:0] v;
        wr(OFS_CMPA, 32'h0000_0000);
        wr(OFS_CTRL, ctl(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, IO_WAVE, MODE_PWM));
        for (int code = 0; code < 8; code++) begin
            wr(OFS_CMPP, DATA_W'(code));
            pwm_win(1024, h, mx);
            `CHK(h, (code == 0) ? 1024 : 128 * code, "duty per p code")
        end
        wr(OFS_CMPA, 32'h0000_00C8);
        wr(OFS_CMPP, 32'h0000_0001);
        pwm_win(200, h, mx);
        `CHK(h, 128, "duty within a period")
        `CHK(mx, 10'h0C7, "top count with period from a")
        rd(OFS_FLAGS, v);
        `CHK(v, 32'h0000_0003, "both match flags")
        `CHK({flag_p, flag_a}, 2'b11, "match flag pins")
        wr(OFS_CTRL, ctl(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, IO_WAVE, MODE_PWM));
        wr(OFS_FLAGS, 32'h0000_0003);
        rd(OFS_FLAGS, v);
        `CHK(v, 32'h0000_0000, "flags cleared")
        `CHK({flag_p, flag_a}, 2'b00, "flag pins cleared")
    endtask

    task automatic pwm_swap_zero();
        int               h;
        logic [CNT_W-1:0] mx;
        logic [CNT_W-1:0] c;
        logic             c_pol[7]  = '{0, 1, 0, 0, 0, 0, 0};
        logic             c_oc[7]   = '{1, 1, 0, 1, 1, 1, 1};
        logic             c_cclr[7] = '{0, 0, 0, 1, 0, 0, 0};
        logic [1:0]       c_io[7]   = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h0, 2'h1};
        int               c_duty[7] = '{64, 64, 64, 64, 300, 64, 64};
        int               c_exp[7]  = '{64, 192, 192, 64, 256, 0, 256};
        wr(OFS_CMPP, 32'h0000_0002);
        for (int i = 0; i < 7; i++) begin
            wr(OFS_CMPA, DATA_W'(c_duty[i]));
            wr(OFS_CTRL, ctl(1'b1, 1'b0, c_cclr[i], c_pol[i], c_oc[i], c_io[i], MODE_PWM));
            pwm_win(256, h, mx);
            `CHK(h, c_exp[i], "duty, polarity, force")
            `CHK(mx, 10'h0FF, "period from p")
        end
        @(posedge clk_sys);
        tick <= 1'b0;
        @(posedge clk_sys);
        c = count;
        repeat (10) @(posedge clk_sys);
        `CHK(count, c, "count holds without tick")
        tick <= 1'b1;
        repeat (3) @(posedge clk_sys);
        `CHK(count === c, 1'b0, "count advances on tick")
        @(posedge clk_sys);
        ce <= 1'b0;
        @(posedge clk_sys);
        c = count;
        repeat (5) @(posedge clk_sys);
        `CHK(count, c, "count frozen by clock enable")
        ce <= 1'b1;
    endtask

    task automatic single_pulse();
        int                h;
        logic [CNT_W-1:0]  c;
        logic [DATA_W-1:0] v;
        wr(OFS_CMPA, 32'h0000_0032);
        wr(OFS_CMPP, 32'h0000_0001);
        wr(OFS_CTRL, ctl(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, IO_PULSE, MODE_PWM));
        wr(OFS_FLAGS, 32'h0000_0003);
        wr(OFS_CTRL, ctl(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, IO_PULSE, MODE_PWM));
        pulse_len(h);
        `CHK(h, 50, "pulse width from a")
        c = count;
        repeat (20) @(posedge clk_sys);
        `CHK(count, c, "counter stopped")
        `CHK(c, 10'h031, "counter stops at match")
        rd(OFS_FLAGS, v);
        `CHK(v[FLAG_A_BIT], 1'b1, "flag a on match")
        `CHK(flag_a, 1'b1, "flag a pin on match")
        rd(OFS_CTRL, v);
        `CHK(v[CTRL_RUN_BIT], 1'b0, "run cleared by match")
        ext_trig <= 1'b1;
        pulse_len(h);
        @(posedge clk_sys);
        ext_trig <= 1'b0;
        `CHK(h, 50, "pin triggered pulse")
        wr(OFS_CMPA, 32'h0000_0000);
        wr(OFS_CTRL, ctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, IO_PULSE, MODE_PWM));
        repeat (10) @(posedge clk_sys);
        `CHK(tmr_out, 1'b1, "pulse active")
        wr(OFS_CTRL, ctl(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, IO_PULSE, MODE_PWM));
        repeat (2) @(posedge clk_sys);
        `CHK(tmr_out, 1'b0, "software trailing edge")
        c = count;
        repeat (5) @(posedge clk_sys);
        `CHK(count, c, "count holds with run clear")
    endtask

    initial begin
        rstn     = 1'b0;
        ce       = 1'b1;
        tick     = 1'b0;
        ext_trig = 1'b0;
        psel     = 1'b0;
        penable  = 1'b0;
        pwrite   = 1'b0;
        paddr    = '0;
        pwdata   = '0;
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        tick <= 1'b1;
        reset_values();
        pwm_swap_one();
        pwm_swap_zero();
        single_pulse();
        conclude();
    end
endmodule
